// [rtl/plm_freq_mon.sv]
`timescale 1ns/10ps
`default_nettype none
module plm_freq_mon
    import plm_pkg::*;
#(
    parameter int unsigned WINDOW = FREQ_WINDOW_TICKS,
    parameter int unsigned WIN_W = 15
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ref_tick,
    input wire logic i_test_tick,
    output logic o_unlock
);
    // allowed tick difference over one window, rounded down
    localparam int unsigned TOL = (WINDOW * PPM_LIMIT) / PPM_SCALE;
    localparam logic [WIN_W+1:0] HI_LIM = (WIN_W+2)'(WINDOW + TOL);
    localparam logic [WIN_W+1:0] LO_LIM = (WIN_W+2)'(WINDOW - TOL);
    localparam logic [WIN_W-1:0] REF_LAST = WIN_W'(WINDOW - 1);
    localparam logic [WIN_W+1:0] TEST_MAX = '1;

    typedef struct packed {
        logic [WIN_W-1:0] ref_cnt;
        logic [WIN_W+1:0] test_cnt;
        logic unlock;
    } plm_fm_state_t;

    plm_fm_state_t st_q, st_d;
    logic [WIN_W+1:0] test_now;

    // count test ticks over a window of reference ticks, judge at window end
    always_comb begin
        st_d = st_q;
        test_now = st_q.test_cnt;
        if (i_test_tick && st_q.test_cnt != TEST_MAX) begin
            test_now = st_q.test_cnt + (WIN_W+2)'(1);
        end
        st_d.test_cnt = test_now;
        if (i_ref_tick) begin
            if (st_q.ref_cnt == REF_LAST) begin
                st_d.unlock = (test_now > HI_LIM) || (test_now < LO_LIM);
                st_d.ref_cnt = '0;
                st_d.test_cnt = '0;
            end else begin
                st_d.ref_cnt = st_q.ref_cnt + WIN_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= '{ref_cnt: '0, test_cnt: '0, unlock: RST_UNLOCK_STATE};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_unlock = st_q.unlock;
endmodule : plm_freq_mon
`default_nettype wire

// [rtl/plm_lock_monitor.sv]
// Function
// - summary two bits 0..4 mirror path, section, wan, rx frame, tx frame requests
// - tx unlock enable at bit 1 lets tx unlock changes raise interrupt
// - tx unlock state bit 3 is one when synth clock off by over 488 ppm
// - tx unlock flag bit 5 sets on state change, clears on register read
// - rx data unlock enable bit 1 lets data unlock changes raise interrupt
// - rx reference unlock enable bit 2 lets reference unlock changes raise interrupt
// - rx data unlock on 488 ppm error or over 80 bits without transition
// - rx reference unlock bit 4 is one while recovery pll not locked
// - rx data unlock flag bit 5 sets on change, clears on read
// - rx reference unlock flag bit 6 sets on change, clears on read
// - jitter mode select high picks wan mode, low picks lan mode
// - loop perf select bit 5: zero favours transfer, one favours tolerance
// - recovery interrupt request appears as recovery source output
`timescale 1ns/10ps
`default_nettype none
module plm_lock_monitor
    import plm_pkg::*;
#(
    parameter int unsigned FREQ_WINDOW = FREQ_WINDOW_TICKS,
    parameter int unsigned WIN_W = 15
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_path_trace_irq_src,
    input wire logic i_section_trace_irq_src,
    input wire logic i_wan_sync_irq_src,
    input wire logic i_rx_frame_proc_irq_src,
    input wire logic i_tx_frame_proc_irq_src,
    input wire logic i_reference_clock_in_tick,
    input wire logic i_synth_clk_tick,
    input wire logic i_recov_clk_tick,
    input wire logic i_rx_bit_tick,
    input wire logic i_rx_transition,
    input wire logic i_recovery_ref_locked,
    output logic o_irq,
    output logic o_recovery_irq_src,
    output logic o_loop_perf_select,
    output logic o_jitter_mode_select
);
    localparam logic [STALE_CNT_W-1:0] STALE_LIMIT = STALE_CNT_W'(NO_TRANSITION_BITS);
    localparam logic [STALE_CNT_W-1:0] STALE_MAX = '1;

    typedef struct packed {
        logic tx_ref_unlock_irq_en;
        logic [2:0] tx_rsvd;
        logic [3:0] synth_rsvd;
        logic rx_data_unlock_irq_en;
        logic rx_ref_unlock_irq_en;
        logic [1:0] rx_rsvd;
        logic [7:0] pll_mode;
        logic tx_ref_unlock_state;
        logic rx_data_unlock_state;
        logic rx_ref_unlock_state;
        logic tx_ref_unlock_flag;
        logic rx_data_unlock_flag;
        logic rx_ref_unlock_flag;
        logic [STALE_CNT_W-1:0] stale_cnt;
        logic [7:0] rdata;
        logic irq;
        logic recovery_irq_src;
    } plm_state_t;

    plm_state_t st_q, st_d;
    logic tx_freq_unlock;
    logic rx_freq_unlock;
    logic tx_new, rxd_new, rxr_new;
    logic rd_tx, rd_rx;
    logic tx_flag_n, rxd_flag_n, rxr_flag_n;
    logic [7:0] tx_csr, rx_csr;

    // frequency comparators for the two plls
    plm_freq_mon #(.WINDOW(FREQ_WINDOW), .WIN_W(WIN_W)) u_tx_mon (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_ref_tick(i_reference_clock_in_tick),
        .i_test_tick(i_synth_clk_tick),
        .o_unlock(tx_freq_unlock)
    );

    plm_freq_mon #(.WINDOW(FREQ_WINDOW), .WIN_W(WIN_W)) u_rx_mon (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_ref_tick(i_reference_clock_in_tick),
        .i_test_tick(i_recov_clk_tick),
        .o_unlock(rx_freq_unlock)
    );

    // next state of the block
    always_comb begin
        st_d = st_q;
        rd_tx = i_rd && (i_addr == ADDR_TX_SYNTH_CTRL_STATUS);
        rd_rx = i_rd && (i_addr == ADDR_RX_RECOVERY_CTRL_STATUS);

        // bit periods without a transition on the serial input
        if (i_rx_transition) begin
            st_d.stale_cnt = '0;
        end else if (i_rx_bit_tick && st_q.stale_cnt != STALE_MAX) begin
            st_d.stale_cnt = st_q.stale_cnt + STALE_CNT_W'(1);
        end

        // lock states
        tx_new = tx_freq_unlock;
        rxd_new = rx_freq_unlock || (st_q.stale_cnt > STALE_LIMIT);
        rxr_new = !i_recovery_ref_locked;
        st_d.tx_ref_unlock_state = tx_new;
        st_d.rx_data_unlock_state = rxd_new;
        st_d.rx_ref_unlock_state = rxr_new;

        // change flags: a change in the read cycle survives the clear
        tx_flag_n = (st_q.tx_ref_unlock_flag && !rd_tx)
            || (tx_new != st_q.tx_ref_unlock_state);
        rxd_flag_n = (st_q.rx_data_unlock_flag && !rd_rx)
            || (rxd_new != st_q.rx_data_unlock_state);
        rxr_flag_n = (st_q.rx_ref_unlock_flag && !rd_rx)
            || (rxr_new != st_q.rx_ref_unlock_state);
        st_d.tx_ref_unlock_flag = tx_flag_n;
        st_d.rx_data_unlock_flag = rxd_flag_n;
        st_d.rx_ref_unlock_flag = rxr_flag_n;

        // register writes
        if (i_wr) begin
            unique case (i_addr)
                ADDR_TX_SYNTH_CTRL_STATUS: begin
                    st_d.tx_ref_unlock_irq_en = i_wdata[BIT_TX_REF_UNLOCK_IRQ_EN];
                    st_d.tx_rsvd = {i_wdata[BIT_TX_RSVD_HI1], i_wdata[BIT_TX_RSVD_HI0],
                        i_wdata[BIT_TX_RSVD_LO]};
                end
                ADDR_TX_SYNTH_RESERVED: begin
                    st_d.synth_rsvd = i_wdata[3:0];
                end
                ADDR_RX_RECOVERY_CTRL_STATUS: begin
                    st_d.rx_data_unlock_irq_en = i_wdata[BIT_RX_DATA_UNLOCK_IRQ_EN];
                    st_d.rx_ref_unlock_irq_en = i_wdata[BIT_RX_REF_UNLOCK_IRQ_EN];
                    st_d.rx_rsvd = {i_wdata[BIT_RX_RSVD_HI], i_wdata[BIT_RX_RSVD_LO]};
                end
                ADDR_RX_RECOVERY_PLL_MODE: begin
                    st_d.pll_mode = i_wdata;
                end
                default: begin
                end
            endcase
        end

        // control and status images as read
        tx_csr = 8'h00;
        tx_csr[BIT_TX_RSVD_HI1] = st_q.tx_rsvd[2];
        tx_csr[BIT_TX_RSVD_HI0] = st_q.tx_rsvd[1];
        tx_csr[BIT_TX_RSVD_LO] = st_q.tx_rsvd[0];
        tx_csr[BIT_TX_REF_UNLOCK_IRQ_EN] = st_q.tx_ref_unlock_irq_en;
        tx_csr[BIT_TX_REF_UNLOCK_STATE] = st_q.tx_ref_unlock_state;
        tx_csr[BIT_TX_REF_UNLOCK_FLAG] = st_q.tx_ref_unlock_flag;
        rx_csr = 8'h00;
        rx_csr[BIT_RX_RSVD_HI] = st_q.rx_rsvd[1];
        rx_csr[BIT_RX_RSVD_LO] = st_q.rx_rsvd[0];
        rx_csr[BIT_RX_DATA_UNLOCK_IRQ_EN] = st_q.rx_data_unlock_irq_en;
        rx_csr[BIT_RX_REF_UNLOCK_IRQ_EN] = st_q.rx_ref_unlock_irq_en;
        rx_csr[BIT_RX_DATA_UNLOCK_STATE] = st_q.rx_data_unlock_state;
        rx_csr[BIT_RX_REF_UNLOCK_STATE] = st_q.rx_ref_unlock_state;
        rx_csr[BIT_RX_DATA_UNLOCK_FLAG] = st_q.rx_data_unlock_flag;
        rx_csr[BIT_RX_REF_UNLOCK_FLAG] = st_q.rx_ref_unlock_flag;

        // read data, valid in the cycle after the strobe only
        st_d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_IRQ_SUMMARY_TWO: begin
                    st_d.rdata[BIT_PATH_TRACE_IRQ_SRC] = i_path_trace_irq_src;
                    st_d.rdata[BIT_SECTION_TRACE_IRQ_SRC] = i_section_trace_irq_src;
                    st_d.rdata[BIT_WAN_SYNC_IRQ_SRC] = i_wan_sync_irq_src;
                    st_d.rdata[BIT_RX_FRAME_PROC_IRQ_SRC] = i_rx_frame_proc_irq_src;
                    st_d.rdata[BIT_TX_FRAME_PROC_IRQ_SRC] = i_tx_frame_proc_irq_src;
                end
                ADDR_TX_SYNTH_CTRL_STATUS: st_d.rdata = tx_csr;
                ADDR_TX_SYNTH_RESERVED: st_d.rdata = {4'h0, st_q.synth_rsvd};
                ADDR_RX_RECOVERY_CTRL_STATUS: st_d.rdata = rx_csr;
                ADDR_RX_RECOVERY_PLL_MODE: st_d.rdata = st_q.pll_mode;
                default: st_d.rdata = 8'h00;
            endcase
        end

        // interrupt requests from the enabled lock flags
        st_d.recovery_irq_src = (rxd_flag_n && st_d.rx_data_unlock_irq_en)
            || (rxr_flag_n && st_d.rx_ref_unlock_irq_en);
        st_d.irq = (tx_flag_n && st_d.tx_ref_unlock_irq_en)
            || st_d.recovery_irq_src;
    end

    // state register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            st_q <= '{
                tx_ref_unlock_irq_en: 1'b0,
                tx_rsvd: 3'h0,
                synth_rsvd: RST_SYNTH_RESERVED,
                rx_data_unlock_irq_en: 1'b0,
                rx_ref_unlock_irq_en: 1'b0,
                rx_rsvd: 2'h0,
                pll_mode: RST_PLL_MODE,
                tx_ref_unlock_state: RST_UNLOCK_STATE,
                rx_data_unlock_state: RST_UNLOCK_STATE,
                rx_ref_unlock_state: RST_UNLOCK_STATE,
                tx_ref_unlock_flag: 1'b0,
                rx_data_unlock_flag: 1'b0,
                rx_ref_unlock_flag: 1'b0,
                stale_cnt: '0,
                rdata: 8'h00,
                irq: 1'b0,
                recovery_irq_src: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign o_rdata = st_q.rdata;
    assign o_irq = st_q.irq;
    assign o_recovery_irq_src = st_q.recovery_irq_src;
    assign o_loop_perf_select = st_q.pll_mode[BIT_LOOP_PERF_SELECT];
    assign o_jitter_mode_select = st_q.pll_mode[BIT_JITTER_MODE_SELECT];
endmodule : plm_lock_monitor
`default_nettype wire

// [rtl/plm_pkg.sv]
package plm_pkg;
    // register offsets
    localparam logic [7:0] ADDR_IRQ_SUMMARY_TWO = 8'h0b;
    localparam logic [7:0] ADDR_TX_SYNTH_CTRL_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TX_SYNTH_RESERVED = 8'h0d;
    localparam logic [7:0] ADDR_RX_RECOVERY_CTRL_STATUS = 8'h0e;
    localparam logic [7:0] ADDR_RX_RECOVERY_PLL_MODE = 8'h0f;

    // summary register bit positions
    localparam int unsigned BIT_PATH_TRACE_IRQ_SRC = 0;
    localparam int unsigned BIT_SECTION_TRACE_IRQ_SRC = 1;
    localparam int unsigned BIT_WAN_SYNC_IRQ_SRC = 2;
    localparam int unsigned BIT_RX_FRAME_PROC_IRQ_SRC = 3;
    localparam int unsigned BIT_TX_FRAME_PROC_IRQ_SRC = 4;

    // transmit synthesis control and status bits
    localparam int unsigned BIT_TX_RSVD_LO = 0;
    localparam int unsigned BIT_TX_REF_UNLOCK_IRQ_EN = 1;
    localparam int unsigned BIT_TX_REF_UNLOCK_STATE = 3;
    localparam int unsigned BIT_TX_REF_UNLOCK_FLAG = 5;
    localparam int unsigned BIT_TX_RSVD_HI0 = 6;
    localparam int unsigned BIT_TX_RSVD_HI1 = 7;

    // receive recovery control and status bits
    localparam int unsigned BIT_RX_RSVD_LO = 0;
    localparam int unsigned BIT_RX_DATA_UNLOCK_IRQ_EN = 1;
    localparam int unsigned BIT_RX_REF_UNLOCK_IRQ_EN = 2;
    localparam int unsigned BIT_RX_DATA_UNLOCK_STATE = 3;
    localparam int unsigned BIT_RX_REF_UNLOCK_STATE = 4;
    localparam int unsigned BIT_RX_DATA_UNLOCK_FLAG = 5;
    localparam int unsigned BIT_RX_REF_UNLOCK_FLAG = 6;
    localparam int unsigned BIT_RX_RSVD_HI = 7;

    // pll mode register bits
    localparam int unsigned BIT_JITTER_MODE_SELECT = 0;
    localparam int unsigned BIT_LOOP_PERF_SELECT = 5;

    // reset values
    localparam logic [7:0] RST_PLL_MODE = 8'h00;
    localparam logic [3:0] RST_SYNTH_RESERVED = 4'h0;
    localparam logic RST_UNLOCK_STATE = 1'b1;

    // lock criteria
    localparam int unsigned PPM_LIMIT = 488;
    localparam int unsigned PPM_SCALE = 1000000;
    localparam int unsigned FREQ_WINDOW_TICKS = 16384;
    localparam int unsigned NO_TRANSITION_BITS = 80;
    localparam int unsigned STALE_CNT_W = 7;
endpackage : plm_pkg

// [tb/plm_far_side.sv]
`timescale 1ns/10ps
`default_nettype none
module plm_far_side (
    input wire logic i_core_clk,
    input wire logic i_synth_bad,
    input wire logic i_recov_bad,
    input wire logic i_line_quiet,
    input wire logic i_ref_lock,
    output logic o_ref_tick,
    output logic o_synth_tick,
    output logic o_recov_tick,
    output logic o_bit_tick,
    output logic o_transition,
    output logic o_ref_locked
);
    logic [5:0] cnt_q = 6'h00;
    // free divider for lost ticks and bit slots
    always @(posedge i_core_clk) begin
        cnt_q <= cnt_q + 6'h01;
    end
    // reference every cycle; an off-frequency clock loses one tick in 64
    assign o_ref_tick = 1'b1;
    assign o_synth_tick = !(i_synth_bad && cnt_q == 6'h00);
    assign o_recov_tick = !(i_recov_bad && cnt_q == 6'h00);
    assign o_bit_tick = cnt_q[0];
    assign o_transition = cnt_q[0] && !i_line_quiet; // quiet line shows no edges
    assign o_ref_locked = i_ref_lock;
endmodule : plm_far_side
`default_nettype wire

// [tb/plm_lock_monitor_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module plm_lock_monitor_properties
    import plm_pkg::*;
#(
    parameter int unsigned FREQ_WINDOW = FREQ_WINDOW_TICKS,
    parameter int unsigned WIN_W = 15
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_path_trace_irq_src,
    input wire logic i_section_trace_irq_src,
    input wire logic i_wan_sync_irq_src,
    input wire logic i_rx_frame_proc_irq_src,
    input wire logic i_tx_frame_proc_irq_src,
    input wire logic i_reference_clock_in_tick,
    input wire logic i_synth_clk_tick,
    input wire logic i_recov_clk_tick,
    input wire logic i_rx_bit_tick,
    input wire logic i_rx_transition,
    input wire logic i_recovery_ref_locked,
    input wire logic o_irq,
    input wire logic o_recovery_irq_src,
    input wire logic o_loop_perf_select,
    input wire logic o_jitter_mode_select
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    // read data only in the slot after a read
    a_rdata_slot_only: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    a_summary_bits_map: assert property (i_rd && i_addr == 8'h0b |=> o_rdata ==
        {3'b000, $past(i_tx_frame_proc_irq_src), $past(i_rx_frame_proc_irq_src),
        $past(i_wan_sync_irq_src), $past(i_section_trace_irq_src), $past(i_path_trace_irq_src)})
        else $error("summary read wrong");
    a_unmapped_reads_zero: assert property (i_rd && (i_addr < 8'h0b || i_addr > 8'h0f)
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_tx_unused_zero: assert property (i_rd && i_addr == 8'h0c |=> o_rdata[4] == 1'b0
        && o_rdata[2] == 1'b0) else $error("tx unused bits set");
    // a flag seen on the second of two reads needs a state change between them
    a_tx_flag_change: assert property ((i_rd && i_addr == 8'h0c)[*2] |=>
        o_rdata[5] -> o_rdata[3] != $past(o_rdata[3])) else $error("tx flag without change");
    a_rx_flags_change: assert property ((i_rd && i_addr == 8'h0e)[*2] |=>
        (o_rdata[6] -> o_rdata[4] != $past(o_rdata[4])) &&
        (o_rdata[5] -> o_rdata[3] != $past(o_rdata[3]))) else $error("rx flag without change");
    a_tx_irq_gate: assert property (i_rd && i_addr == 8'h0c |=>
        (o_rdata[5] && o_rdata[1]) -> $past(o_irq)) else $error("tx irq missing");
    a_rx_irq_gate: assert property (i_rd && i_addr == 8'h0e |=>
        $past(o_recovery_irq_src) == ((o_rdata[6] && o_rdata[2]) || (o_rdata[5] && o_rdata[1])))
        else $error("recovery irq mismatch");
    a_recov_in_irq: assert property (o_recovery_irq_src |-> o_irq)
        else $error("irq low with recovery request");
    a_mode_write: assert property (i_wr && i_addr == 8'h0f |=>
        o_loop_perf_select == $past(i_wdata[5]) && o_jitter_mode_select == $past(i_wdata[0]))
        else $error("mode outputs not written");
    a_mode_hold: assert property (!(i_wr && i_addr == 8'h0f) |=>
        $stable(o_loop_perf_select) && $stable(o_jitter_mode_select)) else $error("mode moved");
endmodule : plm_lock_monitor_properties
bind plm_lock_monitor plm_lock_monitor_properties #(.FREQ_WINDOW(FREQ_WINDOW), .WIN_W(WIN_W))
    plm_lock_monitor_properties_i (.*);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_core_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic i_path_trace_irq_src = 1'b0, i_section_trace_irq_src = 1'b0, i_wan_sync_irq_src = 1'b0;
    logic i_rx_frame_proc_irq_src = 1'b0, i_tx_frame_proc_irq_src = 1'b0;
    logic i_reference_clock_in_tick, i_synth_clk_tick, i_recov_clk_tick, i_rx_bit_tick;
    logic i_rx_transition, i_recovery_ref_locked, o_irq, o_recovery_irq_src;
    logic o_loop_perf_select, o_jitter_mode_select;
    logic synth_bad = 1'b0, recov_bad = 1'b0, line_quiet = 1'b0, ref_lock = 1'b0;
    int err_total = 0, cmp_count = 0;
    // 40 MHz clock
    always #12.5 i_core_clk = ~i_core_clk;
    plm_lock_monitor #(.FREQ_WINDOW(2048), .WIN_W(11)) plm_lock_monitor_i (.*);
    plm_far_side plm_far_side_i (.i_core_clk(i_core_clk), .i_synth_bad(synth_bad),
        .i_recov_bad(recov_bad), .i_line_quiet(line_quiet), .i_ref_lock(ref_lock),
        .o_ref_tick(i_reference_clock_in_tick), .o_synth_tick(i_synth_clk_tick),
        .o_recov_tick(i_recov_clk_tick), .o_bit_tick(i_rx_bit_tick),
        .o_transition(i_rx_transition), .o_ref_locked(i_recovery_ref_locked));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    // one read, or two back to back when two is set
    task rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1, input bit two);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        if (!two) i_rd <= 1'b0;
        #1 chk(o_rdata, e0);
        if (two) begin
            @(posedge i_core_clk);
            i_rd <= 1'b0;
            #1 chk(o_rdata, e1);
        end
    endtask : rd
    task t_reset_regs;
        rd(8'h0c, 8'h08, 8'h08, 1);
        rd(8'h0e, 8'h18, 8'h18, 1);
        rd(8'h0d, 8'h00, 8'h00, 0);
        rd(8'h0f, 8'h00, 8'h00, 0);
        $display("reset values done");
    endtask : t_reset_regs
    task t_summary_regs;
        for (int i = 0; i < 5; i++) begin
            {i_tx_frame_proc_irq_src, i_rx_frame_proc_irq_src, i_wan_sync_irq_src,
                i_section_trace_irq_src, i_path_trace_irq_src} <= 5'h01 << i;
            rd(8'h0b, 8'h01 << i, 8'h00, 0);
        end
        {i_tx_frame_proc_irq_src, i_rx_frame_proc_irq_src, i_wan_sync_irq_src,
            i_section_trace_irq_src, i_path_trace_irq_src} <= 5'h00;
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h00, 8'h00, 0);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00, 8'h00, 0);
        wr(8'h0f, 8'h21);
        tick(1);
        chk({6'h00, o_loop_perf_select, o_jitter_mode_select}, 8'h03);
        rd(8'h0f, 8'h21, 8'h00, 0);
        wr(8'h0f, 8'h00);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h0f, 8'h00, 0);
        wr(8'h0d, 8'h00);
        $display("summary and mode done");
    endtask : t_summary_regs
    task t_tx_lock;
        wr(8'h0c, 8'h02);
        tick(4200);
        chk({7'h00, o_irq}, 8'h01);
        rd(8'h0c, 8'h22, 8'h02, 1);
        chk({7'h00, o_irq}, 8'h00);
        synth_bad <= 1'b1;
        tick(4200);
        rd(8'h0c, 8'h2a, 8'h0a, 1);
        wr(8'h0c, 8'h00);
        synth_bad <= 1'b0;
        tick(4200);
        chk({7'h00, o_irq}, 8'h00);
        rd(8'h0c, 8'h20, 8'h00, 1);
        $display("transmit lock done");
    endtask : t_tx_lock
    task t_rx_lock;
        wr(8'h0e, 8'h06);
        tick(1);
        chk({7'h00, o_recovery_irq_src}, 8'h01);
        rd(8'h0e, 8'h36, 8'h16, 1);
        ref_lock <= 1'b1;
        tick(4);
        chk({7'h00, o_recovery_irq_src}, 8'h01);
        rd(8'h0e, 8'h46, 8'h06, 1);
        line_quiet <= 1'b1;
        tick(150);
        line_quiet <= 1'b0;
        tick(4);
        rd(8'h0e, 8'h06, 8'h00, 0);
        line_quiet <= 1'b1;
        tick(200);
        rd(8'h0e, 8'h2e, 8'h0e, 1);
        line_quiet <= 1'b0;
        tick(4);
        rd(8'h0e, 8'h26, 8'h06, 1);
        recov_bad <= 1'b1;
        tick(4200);
        rd(8'h0e, 8'h2e, 8'h0e, 1);
        wr(8'h0e, 8'h04);
        recov_bad <= 1'b0;
        tick(4200);
        chk({6'h00, o_recovery_irq_src, o_irq}, 8'h00);
        rd(8'h0e, 8'h24, 8'h04, 1);
        $display("receive lock done");
    endtask : t_rx_lock
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge i_core_clk);
        err_total++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_reset <= 1'b0;
        t_reset_regs;
        t_summary_regs;
        t_tx_lock;
        t_rx_lock;
        test_done;
    end
endmodule : testbench
`default_nettype wire
